// [shared/ccr_pkg.sv]
package ccr_pkg;

   // ---------------------------------------------------------------
   // sensed level codes on a cc pin, as given by the comparators
   // ---------------------------------------------------------------
   localparam logic [1:0] LVL_OPEN = 2'h0;
   localparam logic [1:0] LVL_RA   = 2'h1;
   localparam logic [1:0] LVL_RD   = 2'h2;
   localparam logic [1:0] LVL_RP   = 2'h3;

   // ---------------------------------------------------------------
   // termination codes driven to the cc pin switches
   // ---------------------------------------------------------------
   localparam logic [1:0] TERM_OPEN = 2'h0;
   localparam logic [1:0] TERM_RD   = 2'h1;
   localparam logic [1:0] TERM_RP   = 2'h2;

   // ---------------------------------------------------------------
   // port type strap and accessory codes
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_DFP = 2'h0;
   localparam logic [1:0] MODE_UFP = 2'h1;
   localparam logic [1:0] MODE_DRP = 2'h2;

   localparam logic [1:0] ACC_NONE  = 2'h0;
   localparam logic [1:0] ACC_DEBUG = 2'h1;
   localparam logic [1:0] ACC_AUDIO = 2'h2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] RST_RP_SEL = 2'h0;
   localparam logic [1:0] RST_ILIM   = 2'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CNT_W               = 16;
   localparam int CLK_PERIOD_NS       = 20;
   localparam int T_CC_DEBOUNCE_NS    = 2000;
   localparam int T_PD_DEBOUNCE_NS    = 1000;
   localparam int T_VBUS_DEBOUNCE_NS  = 1000;
   localparam int T_DRP_NS            = 20000;
   localparam int DC_DFP_DRP_PCT      = 30;
   localparam int T_DRP_TRANSITION_NS = 200;
   localparam int T_DRP_HOLD_NS       = 10000;

   // least times round up, longest times round down
   localparam int CYC_CC_DEBOUNCE   =
      (T_CC_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_PD_DEBOUNCE   =
      (T_PD_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_VBUS_DEBOUNCE =
      (T_VBUS_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_DRP           = T_DRP_NS / CLK_PERIOD_NS;
   localparam int CYC_DRP_DFP       = (CYC_DRP * DC_DFP_DRP_PCT) / 100;
   localparam int CYC_DRP_TRANSITION =
      (T_DRP_TRANSITION_NS / CLK_PERIOD_NS < 1) ? 1 :
      T_DRP_TRANSITION_NS / CLK_PERIOD_NS;
   localparam int CYC_DRP_HOLD      =
      (T_DRP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // connection states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_SRC_WAIT  = 4'h1,
      ST_SNK_WAIT  = 4'h2,
      ST_ATTACHED  = 4'h4,
      ST_ACCESSORY = 4'h8
   } ccr_state_e;

endpackage

// [shared/ccr_deb_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface ccr_deb_if #(
   parameter int W = 1
);
   logic [W-1:0] raw;
   logic [W-1:0] stable;

   modport filt (input raw, output stable);
   modport user (output raw, input stable);
endinterface

`default_nettype wire

// [src/ccr_debounce.sv]
`timescale 1ns/10ps
`default_nettype none

module ccr_debounce #(
   parameter int W   = 1,
   parameter int CNT = 1
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   ccr_deb_if.filt   d
);

   typedef struct packed {
      logic [W-1:0]              cand;
      logic [W-1:0]              stable;
      logic [ccr_pkg::CNT_W-1:0] cnt;
   } ccr_deb_s;

   localparam int CW = ccr_pkg::CNT_W;

   localparam logic [CW-1:0] LAST = CW'(CNT - 1);

   ccr_deb_s s_reg;
   ccr_deb_s s_next;

   always_comb
   begin
      s_next = s_reg;
      if (d.raw != s_reg.cand)
      begin
         s_next.cand = d.raw;
         s_next.cnt  = '0;
      end
      else if (s_reg.cnt >= LAST)
      begin
         s_next.stable = s_reg.cand;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign d.stable = s_reg.stable;

endmodule

`default_nettype wire

// [src/ccr_attach_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

module ccr_attach_ctrl #(
   parameter int CYC_CC_DEB   = ccr_pkg::CYC_CC_DEBOUNCE,
   parameter int CYC_PD_DEB   = ccr_pkg::CYC_PD_DEBOUNCE,
   parameter int CYC_VBUS_DEB = ccr_pkg::CYC_VBUS_DEBOUNCE,
   parameter int CYC_DRP      = ccr_pkg::CYC_DRP,
   parameter int CYC_DRP_DFP  = ccr_pkg::CYC_DRP_DFP,
   parameter int CYC_DRP_TRAN = ccr_pkg::CYC_DRP_TRANSITION,
   parameter int CYC_DRP_HOLD = ccr_pkg::CYC_DRP_HOLD
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] port_mode_i,
   input  wire logic [1:0] cc1_lvl_i,
   input  wire logic [1:0] cc2_lvl_i,
   input  wire logic       vbus_present_i,
   input  wire logic [1:0] rp_level_i,
   input  wire logic [1:0] snk_adv_i,
   input  wire logic       pr_swap_i,
   input  wire logic       dr_swap_i,
   input  wire logic       vconn_swap_i,
   output logic [1:0]      cc1_term_o,
   output logic [1:0]      cc2_term_o,
   output logic [1:0]      rp_sel_o,
   output logic            vbus_en_o,
   output logic            vconn1_en_o,
   output logic            vconn2_en_o,
   output logic            ss_flip_o,
   output logic            attached_o,
   output logic            data_dfp_o,
   output logic            power_src_o,
   output logic [1:0]      accessory_o,
   output logic [1:0]      ilim_o
);

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   localparam int CW = ccr_pkg::CNT_W;

   localparam logic [CW-1:0] DRP_LAST = CW'(CYC_DRP - 1);
   localparam logic [CW-1:0] DFP_LAST = CW'(CYC_DRP_DFP - 1);
   localparam logic [CW-1:0] TRAN_CYC = CW'(CYC_DRP_TRAN);
   localparam logic [CW-1:0] HOLD_CYC = CW'(CYC_DRP_HOLD);

   typedef struct packed {
      ccr_pkg::ccr_state_e st;
      logic [CW-1:0]       tmr;
      logic [CW-1:0]       settle;
      logic [CW-1:0]       hold;
      logic                flip;
      logic                vbus_en;
      logic                vconn_src;
      logic                vconn1;
      logic                vconn2;
      logic                data_dfp;
      logic                power_src;
      logic                term_rp;
      logic                attached;
      logic [1:0]          cc1_term;
      logic [1:0]          cc2_term;
      logic [1:0]          rp_sel;
      logic [1:0]          ilim;
      logic [1:0]          acc;
   } ccr_ctrl_s;

   ccr_ctrl_s s_reg;
   ccr_ctrl_s s_next;

   // ---------------------------------------------------------------
   // debounce filters
   // ---------------------------------------------------------------
   ccr_deb_if #(.W(4)) cc_att ();
   ccr_deb_if #(.W(4)) cc_pd ();
   ccr_deb_if #(.W(1)) vb_deb ();

   assign cc_att.raw = {cc2_lvl_i, cc1_lvl_i};
   assign cc_pd.raw  = {cc2_lvl_i, cc1_lvl_i};
   assign vb_deb.raw = vbus_present_i;

   ccr_debounce #(
      .W   (4),
      .CNT (CYC_CC_DEB)
   ) u_deb_att (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d     (cc_att.filt)
   );

   ccr_debounce #(
      .W   (4),
      .CNT (CYC_PD_DEB)
   ) u_deb_pd (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d     (cc_pd.filt)
   );

   ccr_debounce #(
      .W   (1),
      .CNT (CYC_VBUS_DEB)
   ) u_deb_vbus (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d     (vb_deb.filt)
   );

   // ---------------------------------------------------------------
   // decoded pin conditions
   // ---------------------------------------------------------------
   logic [1:0] a1;
   logic [1:0] a2;
   logic [1:0] act_pd;
   logic       ufp_seen;
   logic       dbg_seen;
   logic       aud_seen;
   logic       vb_ok;
   logic       detach;

   always_comb
   begin
      a1       = cc_att.stable[1:0];
      a2       = cc_att.stable[3:2];
      vb_ok    = vb_deb.stable[0];
      // exactly one pin carries Rd; the other is open or a cable Ra
      ufp_seen = ((a1 == ccr_pkg::LVL_RD) &&
                  (a2 == ccr_pkg::LVL_OPEN || a2 == ccr_pkg::LVL_RA)) ||
                 ((a2 == ccr_pkg::LVL_RD) &&
                  (a1 == ccr_pkg::LVL_OPEN || a1 == ccr_pkg::LVL_RA));
      dbg_seen = (a1 == ccr_pkg::LVL_RD) && (a2 == ccr_pkg::LVL_RD);
      aud_seen = (a1 == ccr_pkg::LVL_RA) && (a2 == ccr_pkg::LVL_RA);
      act_pd   = s_reg.flip ? cc_pd.stable[3:2] : cc_pd.stable[1:0];
      if (s_reg.power_src)
         detach = (act_pd != ccr_pkg::LVL_RD);
      else
         detach = !vb_ok;
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_next        = s_reg;
      s_next.rp_sel = rp_level_i;
      if (s_reg.settle != '0)
         s_next.settle = s_reg.settle - 1'b1;
      if (s_reg.hold != '0)
         s_next.hold = s_reg.hold - 1'b1;

      case (s_reg.st)
         ccr_pkg::ST_SRC_WAIT:
         begin
            s_next.vbus_en = 1'b0;
            s_next.tmr     = s_reg.tmr + 1'b1;
            if (port_mode_i == ccr_pkg::MODE_UFP)
            begin
               s_next.st  = ccr_pkg::ST_SNK_WAIT;
               s_next.tmr = '0;
            end
            else if (s_reg.settle == '0 && ufp_seen)
            begin
               s_next.st        = ccr_pkg::ST_ATTACHED;
               s_next.flip      = (a2 == ccr_pkg::LVL_RD);
               s_next.attached  = 1'b1;
               s_next.data_dfp  = 1'b1;
               s_next.power_src = 1'b1;
               s_next.term_rp   = 1'b1;
               s_next.vbus_en   = 1'b1;
               // vconn only where a cable load sits on the spare pin
               s_next.vconn_src = (a1 == ccr_pkg::LVL_RA) ||
                                  (a2 == ccr_pkg::LVL_RA);
               s_next.tmr       = '0;
               if (port_mode_i == ccr_pkg::MODE_DRP)
                  s_next.hold = HOLD_CYC;
            end
            else if (s_reg.settle == '0 && (dbg_seen || aud_seen))
            begin
               s_next.st  = ccr_pkg::ST_ACCESSORY;
               s_next.acc = dbg_seen ? ccr_pkg::ACC_DEBUG :
                                       ccr_pkg::ACC_AUDIO;
               s_next.tmr = '0;
            end
            else if (port_mode_i == ccr_pkg::MODE_DRP &&
                     s_reg.tmr >= DFP_LAST)
            begin
               s_next.st     = ccr_pkg::ST_SNK_WAIT;
               s_next.settle = TRAN_CYC;
            end
         end

         ccr_pkg::ST_SNK_WAIT:
         begin
            s_next.vbus_en = 1'b0;
            s_next.tmr     = s_reg.tmr + 1'b1;
            if (port_mode_i == ccr_pkg::MODE_DFP)
            begin
               s_next.st  = ccr_pkg::ST_SRC_WAIT;
               s_next.tmr = '0;
            end
            else if (s_reg.settle == '0 && vb_ok)
            begin
               s_next.st        = ccr_pkg::ST_ATTACHED;
               s_next.flip      = (a2 == ccr_pkg::LVL_RP);
               s_next.attached  = 1'b1;
               s_next.data_dfp  = 1'b0;
               s_next.power_src = 1'b0;
               s_next.term_rp   = 1'b0;
               s_next.vconn_src = 1'b0;
               s_next.tmr       = '0;
            end
            else if (port_mode_i == ccr_pkg::MODE_DRP &&
                     s_reg.tmr >= DRP_LAST)
            begin
               s_next.st     = ccr_pkg::ST_SRC_WAIT;
               s_next.tmr    = '0;
               s_next.settle = TRAN_CYC;
            end
         end

         ccr_pkg::ST_ATTACHED:
         begin
            if (detach)
            begin
               // supplies off and roles cleared before searching again
               s_next.st        = (port_mode_i == ccr_pkg::MODE_UFP) ?
                                  ccr_pkg::ST_SNK_WAIT :
                                  ccr_pkg::ST_SRC_WAIT;
               s_next.attached  = 1'b0;
               s_next.vbus_en   = 1'b0;
               s_next.vconn_src = 1'b0;
               s_next.data_dfp  = 1'b0;
               s_next.power_src = 1'b0;
               s_next.term_rp   = 1'b0;
               s_next.flip      = 1'b0;
               s_next.hold      = '0;
               s_next.tmr       = '0;
               s_next.settle    = TRAN_CYC;
            end
            else if (s_reg.hold == '0)
            begin
               // the role hold after a toggled source attach blocks all swaps
               if (pr_swap_i)
               begin
                  s_next.power_src = !s_reg.power_src;
                  s_next.term_rp   = !s_reg.term_rp;
                  s_next.vbus_en   = !s_reg.power_src;
               end
               if (dr_swap_i)
                  s_next.data_dfp = !s_reg.data_dfp;
               if (vconn_swap_i)
                  s_next.vconn_src = !s_reg.vconn_src;
            end
         end

         ccr_pkg::ST_ACCESSORY:
         begin
            s_next.vbus_en = 1'b0;
            if ((s_reg.acc == ccr_pkg::ACC_DEBUG && !dbg_seen) ||
                (s_reg.acc == ccr_pkg::ACC_AUDIO && !aud_seen))
            begin
               s_next.st     = (port_mode_i == ccr_pkg::MODE_UFP) ?
                               ccr_pkg::ST_SNK_WAIT :
                               ccr_pkg::ST_SRC_WAIT;
               s_next.acc    = ccr_pkg::ACC_NONE;
               s_next.tmr    = '0;
               s_next.settle = TRAN_CYC;
            end
         end

         default:
         begin
            s_next.st = ccr_pkg::ST_SRC_WAIT;
         end
      endcase

      // a sink keeps its load within what the source advertises
      if (s_next.attached && !s_next.power_src)
         s_next.ilim = snk_adv_i;
      else
         s_next.ilim = ccr_pkg::RST_ILIM;

      // vconn goes to the pin the cable does not carry through
      s_next.vconn1 = s_next.attached && s_next.vconn_src && s_next.flip;
      s_next.vconn2 = s_next.attached && s_next.vconn_src && !s_next.flip;

      case (s_next.st)
         ccr_pkg::ST_SRC_WAIT,
         ccr_pkg::ST_ACCESSORY:
         begin
            s_next.cc1_term = ccr_pkg::TERM_RP;
            s_next.cc2_term = ccr_pkg::TERM_RP;
         end
         ccr_pkg::ST_ATTACHED:
         begin
            s_next.cc1_term = s_next.term_rp ? ccr_pkg::TERM_RP :
                                               ccr_pkg::TERM_RD;
            s_next.cc2_term = s_next.cc1_term;
            // the pull on the vconn pin is released while it is powered
            if (s_next.vconn1)
               s_next.cc1_term = ccr_pkg::TERM_OPEN;
            if (s_next.vconn2)
               s_next.cc2_term = ccr_pkg::TERM_OPEN;
         end
         default:
         begin
            s_next.cc1_term = ccr_pkg::TERM_RD;
            s_next.cc2_term = ccr_pkg::TERM_RD;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_reg          <= '0;
         s_reg.st       <= ccr_pkg::ST_SRC_WAIT;
         s_reg.rp_sel   <= ccr_pkg::RST_RP_SEL;
         s_reg.ilim     <= ccr_pkg::RST_ILIM;
         s_reg.acc      <= ccr_pkg::ACC_NONE;
         s_reg.cc1_term <= ccr_pkg::TERM_OPEN;
         s_reg.cc2_term <= ccr_pkg::TERM_OPEN;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cc1_term_o  = s_reg.cc1_term;
   assign cc2_term_o  = s_reg.cc2_term;
   assign rp_sel_o    = s_reg.rp_sel;
   assign vbus_en_o   = s_reg.vbus_en;
   assign vconn1_en_o = s_reg.vconn1;
   assign vconn2_en_o = s_reg.vconn2;
   assign ss_flip_o   = s_reg.flip;
   assign attached_o  = s_reg.attached;
   assign data_dfp_o  = s_reg.data_dfp;
   assign power_src_o = s_reg.power_src;
   assign accessory_o = s_reg.acc;
   assign ilim_o      = s_reg.ilim;

endmodule

`default_nettype wire

// [testbench/ccr_attach_ctrl_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

module ccr_attach_ctrl_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [1:0] cc1_lvl_i,
   input wire logic [1:0] cc2_lvl_i,
   input wire logic       vbus_present_i,
   input wire logic [1:0] rp_level_i,
   input wire logic [1:0] snk_adv_i,
   input wire logic       pr_swap_i,
   input wire logic       dr_swap_i,
   input wire logic       vconn_swap_i,
   input wire logic [1:0] cc1_term_o,
   input wire logic [1:0] cc2_term_o,
   input wire logic [1:0] rp_sel_o,
   input wire logic       vbus_en_o,
   input wire logic       vconn1_en_o,
   input wire logic       vconn2_en_o,
   input wire logic       ss_flip_o,
   input wire logic       attached_o,
   input wire logic       data_dfp_o,
   input wire logic       power_src_o,
   input wire logic [1:0] ilim_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // supply and termination
   // ---------------------------------------------------------------
   AST_RP_SEL: assert property (!$past(rst_i) |-> rp_sel_o == $past(rp_level_i))
      else $error("pull-up select did not follow request");
   AST_NO_SUPPLY: assert property (!attached_o |-> !vbus_en_o && !vconn1_en_o && !vconn2_en_o)
      else $error("supply on while unattached");
   AST_VBUS_SRC: assert property (vbus_en_o |-> power_src_o)
      else $error("vbus on while sink");
   AST_ACT_TERM: assert property (attached_o |-> (ss_flip_o ? cc2_term_o : cc1_term_o)
      == (power_src_o ? ccr_pkg::TERM_RP : ccr_pkg::TERM_RD))
      else $error("active pin termination wrong for role");
   AST_VCONN_SPARE: assert property ((vconn1_en_o |-> ss_flip_o && cc1_term_o == ccr_pkg::TERM_OPEN)
      and (vconn2_en_o |-> !ss_flip_o && cc2_term_o == ccr_pkg::TERM_OPEN))
      else $error("vconn not on released spare pin");
   AST_ILIM: assert property (attached_o && !power_src_o && $past(attached_o && !power_src_o)
      |-> ilim_o == $past(snk_adv_i))
      else $error("current limit not tracking advertisement");

   // ---------------------------------------------------------------
   // attach causes and swaps
   // ---------------------------------------------------------------
   AST_DFP_ORIENT: assert property ($rose(attached_o) && power_src_o |->
      (ss_flip_o ? $past(cc2_lvl_i, 2) : $past(cc1_lvl_i, 2)) == ccr_pkg::LVL_RD)
      else $error("source attach without pull-down on active pin");
   AST_UFP_VBUS: assert property ($rose(attached_o) && !power_src_o |-> $past(vbus_present_i))
      else $error("sink attach without vbus");
   AST_DR_ONLY: assert property (attached_o && $past(attached_o) && $changed(data_dfp_o)
      |-> $past(dr_swap_i))
      else $error("data role changed without swap");
   AST_VCONN_CAUSE: assert property (attached_o && $past(attached_o)
      && !$stable({vconn1_en_o, vconn2_en_o}) |-> $past(vconn_swap_i))
      else $error("vconn changed without vconn swap");
   AST_PR_KEEP: assert property (attached_o && $past(attached_o) && $changed(power_src_o)
      && !$past(vconn_swap_i | dr_swap_i) |->
      $past(pr_swap_i) ##0 $stable({vconn1_en_o, vconn2_en_o, data_dfp_o}))
      else $error("power swap disturbed vconn or data role");
endmodule

bind ccr_attach_ctrl ccr_attach_ctrl_chk u_chk (.*);

`default_nettype wire

// [testbench/ccr_partner.sv]
`timescale 1ns/10ps
`default_nettype none

// kinds: 0 none, 1 dual port, 2 sink only, 3 debug, 4 audio
module ccr_partner (
   input  wire logic [2:0] kind_i,
   input  wire logic       flip_i,
   input  wire logic       ra_i,
   input  wire logic       own_vbus_i,
   input  wire logic [1:0] cc1_term_i,
   input  wire logic [1:0] cc2_term_i,
   output logic [1:0]      cc1_lvl_o,
   output logic [1:0]      cc2_lvl_o,
   output logic            vbus_o
);
   logic [1:0] act_term;
   logic [1:0] act_lvl;
   logic [1:0] spr_lvl;

   assign act_term = flip_i ? cc2_term_i : cc1_term_i;

   always_comb
   begin
      act_lvl = ccr_pkg::LVL_OPEN;
      spr_lvl = (ra_i && kind_i != 3'h0) ? ccr_pkg::LVL_RA : ccr_pkg::LVL_OPEN;
      case (kind_i)
         3'h1: act_lvl = (act_term == ccr_pkg::TERM_RP) ? ccr_pkg::LVL_RD :
                         (act_term == ccr_pkg::TERM_RD) ? ccr_pkg::LVL_RP :
                         ccr_pkg::LVL_OPEN;
         3'h2: act_lvl = (act_term == ccr_pkg::TERM_RP) ? ccr_pkg::LVL_RD :
                         ccr_pkg::LVL_OPEN;
         3'h3: {act_lvl, spr_lvl} = {ccr_pkg::LVL_RD, ccr_pkg::LVL_RD};
         3'h4: {act_lvl, spr_lvl} = {ccr_pkg::LVL_RA, ccr_pkg::LVL_RA};
         default: spr_lvl = ccr_pkg::LVL_OPEN;
      endcase
   end

   assign cc1_lvl_o = flip_i ? spr_lvl : act_lvl;
   assign cc2_lvl_o = flip_i ? act_lvl : spr_lvl;
   // sources vbus only while the device sinks; removed on unplug
   assign vbus_o = (kind_i != 3'h0) && (own_vbus_i
                   || (kind_i == 3'h1 && act_term == ccr_pkg::TERM_RD));
endmodule

`default_nettype wire

// [testbench/ccr_attach_ctrl_test.sv]
`timescale 1ns/10ps
`default_nettype none

module ccr_attach_ctrl_test;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [1:0] port_mode_i = ccr_pkg::MODE_DFP;
   logic [1:0] cc1_lvl_i;
   logic [1:0] cc2_lvl_i;
   logic       vbus_present_i;
   logic [1:0] rp_level_i = 2'h1;
   logic [1:0] snk_adv_i = 2'h2;
   logic       pr_swap_i = 1'b0;
   logic       dr_swap_i = 1'b0;
   logic       vconn_swap_i = 1'b0;
   logic [1:0] cc1_term_o;
   logic [1:0] cc2_term_o;
   logic [1:0] rp_sel_o;
   logic       vbus_en_o;
   logic       vconn1_en_o;
   logic       vconn2_en_o;
   logic       ss_flip_o;
   logic       attached_o;
   logic       data_dfp_o;
   logic       power_src_o;
   logic [1:0] accessory_o;
   logic [1:0] ilim_o;
   logic [2:0] kind = 3'h0;
   logic       flip = 1'b0;
   logic       ra = 1'b0;
   logic [6:0] st;
   int         n_mismatch = 0;
   int         checks = 0;

   assign st = {attached_o, vbus_en_o, vconn1_en_o, vconn2_en_o,
                ss_flip_o, data_dfp_o, power_src_o};

   always #10 clk_i = ~clk_i;

   // role settle and role hold keep their default cycle counts
   ccr_attach_ctrl #(.CYC_CC_DEB(4), .CYC_PD_DEB(3), .CYC_VBUS_DEB(3),
      .CYC_DRP(40), .CYC_DRP_DFP(12))
      u_dut (.*);

   ccr_partner u_partner (.kind_i(kind), .flip_i(flip), .ra_i(ra),
      .own_vbus_i(vbus_en_o), .cc1_term_i(cc1_term_o),
      .cc2_term_i(cc2_term_o), .cc1_lvl_o(cc1_lvl_i),
      .cc2_lvl_o(cc2_lvl_i), .vbus_o(vbus_present_i));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_att(input logic v);
      repeat (200) if (attached_o !== v) @(negedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic pulse(input logic [2:0] s);
      {pr_swap_i, dr_swap_i, vconn_swap_i} = s;
      @(negedge clk_i);
      {pr_swap_i, dr_swap_i, vconn_swap_i} = 3'h0;
      @(negedge clk_i);
   endtask

   task automatic end_sim;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_dfp_swaps;
      kind = 3'h1;
      flip = 1'b1;
      ra = 1'b1;
      wait_att(1'b1);
      chk(st, 7'h77);
      chk({5'h0, cc1_term_o}, {5'h0, ccr_pkg::TERM_OPEN});
      rp_level_i = 2'h3;
      @(negedge clk_i);
      chk({5'h0, rp_sel_o}, 7'h03);
      pulse(3'h2);
      chk(st, 7'h75);
      pulse(3'h1);
      chk(st, 7'h65);
      pulse(3'h4);
      chk(st, 7'h44);
      chk({5'h0, cc2_term_o}, {5'h0, ccr_pkg::TERM_RD});
      kind = 3'h0;
      wait_att(1'b0);
      chk(st, 7'h00);
   endtask

   task automatic t_ufp;
      port_mode_i = ccr_pkg::MODE_UFP;
      ra = 1'b0;
      kind = 3'h1;
      wait_att(1'b1);
      chk(st, 7'h44);
      chk({3'h0, cc1_term_o, cc2_term_o}, {3'h0, ccr_pkg::TERM_RD, ccr_pkg::TERM_RD});
      snk_adv_i = 2'h3;
      repeat (2) @(negedge clk_i);
      chk({5'h0, ilim_o}, 7'h03);
      kind = 3'h0;
      wait_att(1'b0);
      chk(st, 7'h00);
      chk({5'h0, ilim_o}, 7'h00);
   endtask

   task automatic t_accessory;
      port_mode_i = ccr_pkg::MODE_DFP;
      for (int k = 3; k <= 4; k++)
      begin
         kind = k[2:0];
         repeat (200) if (accessory_o === ccr_pkg::ACC_NONE) @(negedge clk_i);
         chk({5'h0, accessory_o}, (k == 3) ? 7'h01 : 7'h02);
         chk(st, 7'h00);
         kind = 3'h0;
         repeat (200) if (accessory_o !== ccr_pkg::ACC_NONE) @(negedge clk_i);
      end
   endtask

   task automatic t_drp;
      port_mode_i = ccr_pkg::MODE_DRP;
      flip = 1'b0;
      repeat (60) if (cc1_term_o !== ccr_pkg::TERM_RD) @(negedge clk_i);
      chk({5'h0, cc1_term_o}, {5'h0, ccr_pkg::TERM_RD});
      repeat (60) if (cc1_term_o !== ccr_pkg::TERM_RP) @(negedge clk_i);
      chk({3'h0, cc1_term_o, vbus_en_o, 1'b0}, {3'h0, ccr_pkg::TERM_RP, 2'h0});
      kind = 3'h2;
      wait_att(1'b1);
      pulse(3'h2);
      chk(st, 7'h63);
      kind = 3'h0;
      wait_att(1'b0);
      chk(st, 7'h00);
   endtask

   initial
   begin
      #50us;
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      repeat (10) @(negedge clk_i);
      chk(st, 7'h00);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk({3'h0, cc1_term_o, cc2_term_o}, {3'h0, ccr_pkg::TERM_RP, ccr_pkg::TERM_RP});
      t_dfp_swaps();
      t_ufp();
      t_accessory();
      t_drp();
      end_sim();
   end
endmodule

`default_nettype wire
